// >>> rtl/dbg_console_pkg.sv
// Shared constants and types for the target debug console logic
`default_nettype none
package dbg_console_pkg;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 16;
  localparam int TRACE_DEPTH = 256;
  localparam int TRACE_AW = 8;
  localparam int ADDR_LSB = 16;
  localparam int DATA_LSB = 8;
  localparam int STAT_LSB = 0;
  localparam int OVL_RAM_BYTES = 128;
  localparam int ROM_USABLE_BYTES = 1920;
  localparam int SUBR_SLOTS = 16;
  localparam int CLK_MHZ = 125;
  localparam int REFRESH_PER_SEC = 10;
  localparam int REFRESH_CYCLES = CLK_MHZ * 1000000 / REFRESH_PER_SEC;
  localparam logic [7:0] PASS_RESET = 8'h00;
  localparam logic [15:0] WIN_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ACT_HALT = 2'b00,
    ACT_PASS = 2'b01,
    ACT_CALL = 2'b10,
    ACT_TRACE = 2'b11
  } bp_action_e;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_HALT = 3'b001,
    CMD_STEP = 3'b010,
    CMD_RESET = 3'b011,
    CMD_RUN = 3'b100,
    CMD_RUN_DISP = 3'b101
  } cpu_cmd_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALTED = 2'b01,
    ST_STEP = 2'b10,
    ST_PAUSE = 2'b11
  } run_state_e;

  function automatic logic [31:0] form_word(input logic [15:0] a, input logic [7:0] d,
                                            input logic [7:0] s);
    form_word = {a, d, s};
  endfunction
endpackage
`default_nettype wire

// >>> rtl/trace_mem_if.sv
// Write and read port bundle between the console logic and its trace store
`default_nettype none
interface trace_mem_if;
  logic we;
  logic [7:0] waddr;
  logic [31:0] wdata;
  logic [7:0] raddr;
  logic [31:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// >>> rtl/trace_mem.sv
// Trace store: 256 words of 32 bits with registered read data
`default_nettype none
module trace_mem
  import dbg_console_pkg::*;
(
  input wire logic ref_clk_i,
  trace_mem_if.mem port
);
  logic [WORD_W-1:0] mem_q [TRACE_DEPTH];
  logic [WORD_W-1:0] rdata_ff;
  always_ff @(posedge ref_clk_i) begin
    if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    rdata_ff <= mem_q[port.raddr];
  end
  assign port.rdata = rdata_ff;
endmodule
`default_nettype wire

// >>> rtl/dbg_console.sv
// Target debug console logic: breakpoint, trace, overlay decode and run control
`default_nettype none
// Operation
// - Compare each cycle to a 32-bit condition, every bit individually maskable.
// - Word is 16-bit address, 8-bit data, 8-bit status.
// - On match do selected action: halt, pass count, call, or trace.
// - Compare combinationally beside the bus, no wait states added.
// - Pass mode halts at first fetch after Nth match, N 1..256.
// - Trace store 256 by 32 bits, written per recorded cycle.
// - Trace writing stops on halt or panel freeze.
// - Trace mode selects all cycles or match cycles only.
// - Step keys move the examined address up or down by one.
// - CPU commands leave breakpoint and trace settings untouched.
// - Halt stops at next opcode fetch; DMA still allowed while halted.
// - Run with display pauses target ten times per second for refresh.
// - Programmable window redirects target accesses to overlay memory.
// - Window's first 128 bytes are RAM, remaining 1920 bytes ROM in a 2K window, 896 bytes in a 1K window.
// - Descriptor area names up to 16 subroutines, each selectable.
// - Selected byte shown in binary and changeable through 8 bit switches.
module dbg_console
  import dbg_console_pkg::*;
#(
  parameter int REFRESH_DIV = REFRESH_CYCLES,
  parameter int PAUSE_CYCLES = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cycle_valid_i,
  input wire logic [15:0] cycle_addr_i,
  input wire logic [7:0] cycle_data_i,
  input wire logic [7:0] cycle_stat_i,
  input wire logic opcode_fetch_i,
  input wire logic dma_req_i,
  input wire logic [31:0] bp_cond_i,
  input wire logic [31:0] bp_mask_i,
  input wire logic bp_enable_i,
  input wire logic [1:0] bp_action_i,
  input wire logic [7:0] pass_count_i,
  input wire logic [15:0] call_addr_i,
  input wire logic trace_all_i,
  input wire logic freeze_i,
  input wire logic [2:0] cpu_cmd_i,
  input wire logic cmd_strobe_i,
  input wire logic [15:0] exam_addr_i,
  input wire logic exam_load_i,
  input wire logic step_up_key_i,
  input wire logic step_down_key_i,
  input wire logic [7:0] trace_sel_i,
  input wire logic [5:0] win_base_i,
  input wire logic win_2k_i,
  input wire logic win_enable_i,
  input wire logic [3:0] subroutine_pick_key_i,
  input wire logic [15:0] subr_enable_i,
  input wire logic [7:0] sel_value_i,
  input wire logic [7:0] bit_switch_i,
  input wire logic bit_switch_load_i,
  output logic bp_match_o,
  output logic sync_n_o,
  output logic halt_req_o,
  output logic cpu_reset_o,
  output logic dma_ack_o,
  output logic call_req_o,
  output logic [15:0] call_target_o,
  output logic [8:0] pass_left_o,
  output logic [15:0] exam_addr_o,
  output logic [31:0] trace_word_o,
  output logic [7:0] trace_wptr_o,
  output logic ovl_ram_sel_o,
  output logic ovl_rom_sel_o,
  output logic [10:0] ovl_offset_o,
  output logic [3:0] subr_active_o,
  output logic subr_ok_o,
  output logic disp_update_o,
  output logic [7:0] binary_disp_o,
  output logic [1:0] run_state_o
);
  trace_mem_if tif();
  trace_mem u_trace (.ref_clk_i(ref_clk_i), .port(tif.mem));
  logic [31:0] cur_word;
  logic match;
  logic halted;
  logic pend_halt_ff;
  logic arm_ff;
  logic [8:0] pass_ff;
  logic [7:0] wptr_ff;
  run_state_e state_ff;
  logic disp_mode_ff;
  logic [31:0] ref_cnt_ff;
  logic [7:0] pause_ff;
  logic [15:0] exam_ff;
  logic [7:0] bin_ff;
  logic call_pend_ff;
  logic do_trace;
  logic [7:0] sel_seen_ff;
  assign cur_word = form_word(cycle_addr_i, cycle_data_i, cycle_stat_i);
  // Pure combinational compare so the target bus is never stretched
  assign match = cycle_valid_i && (((cur_word ^ bp_cond_i) & ~bp_mask_i) == 32'h0);
  assign bp_match_o = match;
  assign sync_n_o = ~match;
  assign halted = (state_ff == ST_HALTED);
  // Pending halt from a breakpoint or the halt command lands on the next opcode fetch
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_halt_ff <= 1'b0;
    end else if (state_ff == ST_HALTED) begin
      pend_halt_ff <= 1'b0;
    end else if (cmd_strobe_i && cpu_cmd_e'(cpu_cmd_i) == CMD_HALT) begin
      pend_halt_ff <= 1'b1;
    end else if (bp_enable_i && match && bp_action_e'(bp_action_i) == ACT_HALT) begin
      pend_halt_ff <= 1'b1;
    end else if (bp_enable_i && match && bp_action_e'(bp_action_i) == ACT_PASS
                 && pass_ff == 9'd1) begin
      pend_halt_ff <= 1'b1;
    end
  end
  // Counter holds remaining matches; count 0 on the keypad means 256
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arm_ff <= 1'b0;
      pass_ff <= 9'h000;
    end else begin
      arm_ff <= bp_enable_i;
      if (bp_enable_i && !arm_ff) begin
        pass_ff <= (pass_count_i == PASS_RESET) ? 9'h100 : {1'b0, pass_count_i};
      end else if (bp_enable_i && match && bp_action_e'(bp_action_i) == ACT_PASS
                   && pass_ff != 9'h000) begin
        pass_ff <= pass_ff - 9'd1;
      end
    end
  end
  assign pass_left_o = pass_ff;
  // Set wins: a match on the fetch that issues a call queues the next call
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      call_pend_ff <= 1'b0;
    end else if (bp_enable_i && match && bp_action_e'(bp_action_i) == ACT_CALL) begin
      call_pend_ff <= 1'b1;
    end else if (cycle_valid_i && opcode_fetch_i && call_pend_ff) begin
      call_pend_ff <= 1'b0;
    end
  end
  assign call_req_o = call_pend_ff && cycle_valid_i && opcode_fetch_i;
  assign call_target_o = call_addr_i;
  // Run control; commands never touch breakpoint or trace settings
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_RUN;
      disp_mode_ff <= 1'b0;
      pause_ff <= 8'h00;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (cmd_strobe_i && cpu_cmd_e'(cpu_cmd_i) == CMD_RUN_DISP) begin
            disp_mode_ff <= 1'b1;
          end else if (cmd_strobe_i && cpu_cmd_e'(cpu_cmd_i) == CMD_RUN) begin
            disp_mode_ff <= 1'b0;
          end
          if (cycle_valid_i && opcode_fetch_i
              && (pend_halt_ff || (cmd_strobe_i && cpu_cmd_e'(cpu_cmd_i) == CMD_HALT))) begin
            state_ff <= ST_HALTED;
          end else if (disp_mode_ff && ref_cnt_ff == 32'd0) begin
            state_ff <= ST_PAUSE;
            pause_ff <= 8'(PAUSE_CYCLES);
          end
        end
        ST_HALTED: begin
          if (cmd_strobe_i && cpu_cmd_e'(cpu_cmd_i) == CMD_STEP) begin
            state_ff <= ST_STEP;
          end else if (cmd_strobe_i && (cpu_cmd_e'(cpu_cmd_i) == CMD_RUN
                       || cpu_cmd_e'(cpu_cmd_i) == CMD_RUN_DISP)) begin
            state_ff <= ST_RUN;
            disp_mode_ff <= (cpu_cmd_e'(cpu_cmd_i) == CMD_RUN_DISP);
          end
        end
        ST_STEP: begin
          // One instruction: release until the next opcode fetch
          if (cycle_valid_i && opcode_fetch_i) begin
            state_ff <= ST_HALTED;
          end
        end
        ST_PAUSE: begin
          if (pause_ff == 8'h00) begin
            state_ff <= ST_RUN;
          end else begin
            pause_ff <= pause_ff - 8'd1;
          end
        end
        default: state_ff <= ST_RUN;
      endcase
    end
  end
  assign run_state_o = state_ff;
  assign halt_req_o = halted || state_ff == ST_PAUSE;
  assign dma_ack_o = dma_req_i && halted;
  assign cpu_reset_o = cmd_strobe_i && cpu_cmd_e'(cpu_cmd_i) == CMD_RESET;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_cnt_ff <= 32'd0;
    end else if (!disp_mode_ff || ref_cnt_ff == 32'd0) begin
      ref_cnt_ff <= 32'(REFRESH_DIV - 1);
    end else begin
      ref_cnt_ff <= ref_cnt_ff - 32'd1;
    end
  end
  // Display refreshes once at the end of each pause; otherwise it holds
  assign disp_update_o = (state_ff == ST_PAUSE) && (pause_ff == 8'h00);
  // Trace recording; match-only mode ignores the breakpoint enable
  assign do_trace = cycle_valid_i && !halted && !freeze_i
                    && (trace_all_i || match);
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_ff <= 8'h00;
    end else if (do_trace) begin
      wptr_ff <= wptr_ff + 8'd1;
    end
  end
  assign tif.we = do_trace;
  assign tif.waddr = wptr_ff;
  assign tif.wdata = cur_word;
  assign tif.raddr = trace_sel_i;
  assign trace_word_o = tif.rdata;
  assign trace_wptr_o = wptr_ff;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      exam_ff <= WIN_RESET;
    end else if (exam_load_i) begin
      exam_ff <= exam_addr_i;
    end else if (step_up_key_i) begin
      exam_ff <= exam_ff + 16'd1;
    end else if (step_down_key_i) begin
      exam_ff <= exam_ff - 16'd1;
    end
  end
  assign exam_addr_o = exam_ff;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bin_ff <= 8'h00;
      sel_seen_ff <= 8'h00;
    end else begin
      sel_seen_ff <= sel_value_i;
      if (bit_switch_load_i) begin
        bin_ff <= bit_switch_i;
      end else if (sel_value_i != sel_seen_ff) begin
        bin_ff <= sel_value_i;
      end
    end
  end
  assign binary_disp_o = bin_ff;
  // Overlay decode; window base in 1K units, 2K windows use an even base
  logic in_win;
  assign in_win = win_enable_i && cycle_valid_i && (win_2k_i
      ? cycle_addr_i[15:11] == win_base_i[5:1] : cycle_addr_i[15:10] == win_base_i);
  assign ovl_offset_o = win_2k_i ? cycle_addr_i[10:0] : {1'b0, cycle_addr_i[9:0]};
  assign ovl_ram_sel_o = in_win && (ovl_offset_o < 11'(OVL_RAM_BYTES));
  assign ovl_rom_sel_o = in_win && !ovl_ram_sel_o;
  assign subr_active_o = subroutine_pick_key_i;
  assign subr_ok_o = subr_enable_i[subroutine_pick_key_i];
  property p_sync;
    @(posedge ref_clk_i) disable iff (rst_i) match |-> !sync_n_o && bp_match_o;
  endproperty
  a_sync: assert property (p_sync) else $error("sync not asserted on match");
  property p_halt_fetch;
    @(posedge ref_clk_i) disable iff (rst_i)
      (state_ff == ST_RUN && pend_halt_ff && cycle_valid_i && opcode_fetch_i)
      |=> state_ff == ST_HALTED;
  endproperty
  a_halt_fetch: assert property (p_halt_fetch) else $error("halt missed at fetch");
  property p_freeze;
    @(posedge ref_clk_i) disable iff (rst_i) (freeze_i || halted) |=> $stable(wptr_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("trace moved while frozen");
  property p_up;
    @(posedge ref_clk_i) disable iff (rst_i)
      (step_up_key_i && !exam_load_i) |=> exam_ff == $past(exam_ff) + 16'd1;
  endproperty
  a_up: assert property (p_up) else $error("step up failed");
  property p_ram;
    @(posedge ref_clk_i) disable iff (rst_i) ovl_ram_sel_o |-> !ovl_rom_sel_o;
  endproperty
  a_ram: assert property (p_ram) else $error("overlay overlap");
  property p_dma;
    @(posedge ref_clk_i) disable iff (rst_i) (halted && dma_req_i) |-> dma_ack_o;
  endproperty
  a_dma: assert property (p_dma) else $error("dma refused while halted");
  property p_trace_all;
    @(posedge ref_clk_i) disable iff (rst_i)
      (cycle_valid_i && trace_all_i && !freeze_i && !halted) |=> wptr_ff == $past(wptr_ff) + 8'd1;
  endproperty
  a_trace_all: assert property (p_trace_all) else $error("trace cycle dropped");
  property p_reload;
    @(posedge ref_clk_i) disable iff (rst_i) (bp_enable_i && !arm_ff)
      |=> pass_ff == (($past(pass_count_i) == 8'h00) ? 9'h100 : {1'b0, $past(pass_count_i)});
  endproperty
  a_reload: assert property (p_reload) else $error("pass reload wrong");
endmodule
`default_nettype wire

// >>> bench/target_bus_model.sv
// Behavioural target bus as seen through the probe
`default_nettype none
module target_bus_model (
  output logic valid_o,
  output logic fetch_o,
  output logic dma_o,
  output logic [15:0] addr_o,
  output logic [7:0] data_o,
  output logic [7:0] stat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {valid_o, fetch_o, dma_o, addr_o, data_o, stat_o} = '0;
  end
  // Caller holds a cycle across one or more sampling edges
  task put(input logic [15:0] a, input logic [7:0] d, input logic [7:0] s, input logic f);
    {valid_o, fetch_o, addr_o, data_o, stat_o} = {1'b1, f, a, d, s};
  endtask
  // Valid and fetch drop and address, data and status invert (DMA is left as is), so a stale cycle can never pass for a fresh one
  task drop();
    {valid_o, fetch_o, addr_o, data_o, stat_o} = {2'b00, ~addr_o, ~data_o, ~stat_o};
  endtask
  task dma(input logic v);
    dma_o = v;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the debug console logic
`default_nettype none
module tb
  import dbg_console_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, rst_i, cycle_valid_i, opcode_fetch_i, dma_req_i, bp_enable_i, trace_all_i;
  logic freeze_i, cmd_strobe_i, exam_load_i, step_up_key_i, step_down_key_i, win_2k_i;
  logic win_enable_i, bit_switch_load_i, bp_match_o, sync_n_o, halt_req_o, cpu_reset_o;
  logic dma_ack_o, call_req_o, ovl_ram_sel_o, ovl_rom_sel_o, subr_ok_o, disp_update_o;
  logic [1:0] bp_action_i, run_state_o;
  logic [2:0] cpu_cmd_i;
  logic [3:0] subroutine_pick_key_i, subr_active_o;
  logic [5:0] win_base_i;
  logic [7:0] cycle_data_i, cycle_stat_i, pass_count_i, trace_sel_i, sel_value_i, bit_switch_i;
  logic [7:0] trace_wptr_o, binary_disp_o;
  logic [8:0] pass_left_o;
  logic [10:0] ovl_offset_o;
  logic [15:0] cycle_addr_i, call_addr_i, exam_addr_i, subr_enable_i, call_target_o, exam_addr_o;
  logic [31:0] bp_cond_i, bp_mask_i, trace_word_o;
  int n_fail, n_checks, nd, np;

  // Short refresh period keeps run-with-display inside a brief run
  dbg_console #(.REFRESH_DIV(50), .PAUSE_CYCLES(4)) uut (.*);
  target_bus_model tgt (.valid_o(cycle_valid_i), .fetch_o(opcode_fetch_i), .dma_o(dma_req_i),
    .addr_o(cycle_addr_i), .data_o(cycle_data_i), .stat_o(cycle_stat_i));

  initial ref_clk_i = 0;
  always #4 ref_clk_i = ~ref_clk_i;

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tick(input int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task cyc(input logic [31:0] wd, input logic f);
    tgt.put(wd[31:16], wd[15:8], wd[7:0], f);
    #2;
  endtask
  task idle();
    tgt.drop();
    tick();
  endtask
  task cmd(input cpu_cmd_e c);
    cpu_cmd_i = c;
    cmd_strobe_i = 1;
    #2;
    if (c == CMD_RESET) chk("cpu_reset", cpu_reset_o, 1);
    tick();
    cmd_strobe_i = 0;
    tick();
  endtask
  task automatic press(ref logic k);
    k = 1;
    tick();
    k = 0;
    tick();
  endtask
  task ov(input logic [15:0] a, input logic [1:0] sel, input logic [10:0] off);
    cyc({a, 16'h0000}, 0);
    chk("overlay_sel", {ovl_ram_sel_o, ovl_rom_sel_o}, sel);
    if (sel != 0) chk("overlay_offset", ovl_offset_o, off);
    tick();
  endtask
  task done_test(input string nm);
    $display("test %s done, mismatches so far %0d", nm, n_fail);
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    tick(3000);
    n_fail++;
    print_verdict();
  end

  initial begin
    rst_i = 1;
    {bp_enable_i, trace_all_i, freeze_i, cmd_strobe_i, exam_load_i, step_up_key_i,
     step_down_key_i, win_2k_i, win_enable_i, bit_switch_load_i, bp_action_i, cpu_cmd_i,
     subroutine_pick_key_i, pass_count_i, trace_sel_i, sel_value_i, bit_switch_i,
     call_addr_i, exam_addr_i, subr_enable_i} = '0;
    win_base_i = 6'h06;
    bp_cond_i = 32'h1234_5678;
    bp_mask_i = 32'h0000_00ff;
    tick(2);
    rst_i = 0;
    chk("reset", {run_state_o, trace_wptr_o, exam_addr_o}, 32'h0000_0000);
    exam_addr_i = 16'h00ff;
    press(exam_load_i);
    press(step_up_key_i);
    chk("exam_addr", exam_addr_o, 16'h0100);
    press(step_down_key_i);
    press(step_down_key_i);
    chk("exam_addr", exam_addr_o, 16'h00fe);
    sel_value_i = 8'h5a;
    subroutine_pick_key_i = 4'h3;
    subr_enable_i = 16'h0008;
    tick();
    chk("binary", binary_disp_o, 8'h5a);
    chk("subr", {subr_active_o, subr_ok_o}, 5'h07);
    subr_enable_i = 16'hfff7;
    bit_switch_i = 8'h81;
    press(bit_switch_load_i);
    chk("binary", binary_disp_o, 8'h81);
    chk("subr", {subr_active_o, subr_ok_o}, 5'h06);
    done_test("panel");
    win_2k_i = 1;
    win_enable_i = 1;
    ov(16'h1800, 2'b10, 11'h000);
    ov(16'h187f, 2'b10, 11'h07f);
    ov(16'h1880, 2'b01, 11'h080);
    ov(16'h1fff, 2'b01, 11'h7ff);
    ov(16'h17ff, 2'b00, 11'h000);
    ov(16'h2000, 2'b00, 11'h000);
    win_2k_i = 0;
    ov(16'h1bff, 2'b01, 11'h3ff);
    ov(16'h1c00, 2'b00, 11'h000);
    win_enable_i = 0;
    ov(16'h1800, 2'b00, 11'h000);
    idle();
    done_test("overlay");
    // Flip each bit of the condition: only masked bits may still match
    for (int i = 0; i < 32; i++) begin
      cyc(bp_cond_i ^ (32'h1 << i), 0);
      chk("bp_match", bp_match_o, bp_mask_i[i]);
      chk("sync_n", sync_n_o, !bp_mask_i[i]);
      tick();
    end
    idle();
    chk("trace_wptr", trace_wptr_o, 8);
    trace_sel_i = 8'h07;
    tick(2);
    chk("trace_word", trace_word_o, bp_cond_i ^ 32'h80);
    trace_all_i = 1;
    repeat (3) begin
      cyc(~bp_cond_i, 0);
      tick();
    end
    chk("trace_wptr", trace_wptr_o, 11);
    freeze_i = 1;
    repeat (2) begin
      cyc(~bp_cond_i, 0);
      tick();
    end
    idle();
    freeze_i = 0;
    chk("trace_wptr", trace_wptr_o, 11);
    done_test("trace");
    bp_action_i = ACT_PASS;
    pass_count_i = 8'h02;
    bp_enable_i = 1;
    tick(2);
    chk("pass_left", pass_left_o, 2);
    cyc(bp_cond_i, 0);
    tick();
    chk("pass_left", pass_left_o, 1);
    cyc(bp_cond_i, 0);
    tick();
    cyc(32'h0000_0000, 1);
    chk("halt_req", halt_req_o, 0);
    tick();
    chk("run_state", run_state_o, ST_HALTED);
    chk("halt_req", halt_req_o, 1);
    bp_enable_i = 0;
    tgt.dma(1);
    cyc(~bp_cond_i, 0);
    chk("dma_ack", dma_ack_o, 1);
    tick();
    idle();
    tgt.dma(0);
    chk("trace_wptr", trace_wptr_o, 14);
    cmd(CMD_RESET);
    cmd(CMD_RUN);
    chk("run_state", run_state_o, ST_RUN);
    cyc(bp_cond_i, 0);
    chk("bp_match", bp_match_o, 1);
    tick();
    idle();
    done_test("pass");
    bp_action_i = ACT_CALL;
    call_addr_i = 16'hbeef;
    pass_count_i = 8'h00;
    bp_enable_i = 1;
    tick();
    chk("pass_left", pass_left_o, 256);
    cyc(bp_cond_i, 0);
    tick();
    cyc(32'h0000_0000, 1);
    chk("call", {call_req_o, call_target_o}, 17'h1beef);
    tick();
    idle();
    bp_enable_i = 0;
    tick();
    bp_action_i = ACT_HALT;
    bp_enable_i = 1;
    tick();
    cyc(bp_cond_i, 0);
    tick();
    cyc(32'h0000_0000, 0);
    tick();
    chk("run_state", run_state_o, ST_RUN);
    cyc(32'h0000_0000, 1);
    tick();
    idle();
    chk("run_state", run_state_o, ST_HALTED);
    bp_enable_i = 0;
    cmd(CMD_RUN);
    tgt.put(16'h0000, 8'h00, 8'h00, 1);
    cmd(CMD_HALT);
    idle();
    chk("run_state", run_state_o, ST_HALTED);
    cmd(CMD_RUN);
    cmd(CMD_HALT);
    chk("run_state", run_state_o, ST_RUN);
    cyc(32'h0000_0000, 1);
    tick();
    idle();
    chk("run_state", run_state_o, ST_HALTED);
    done_test("actions");
    cmd(CMD_RUN_DISP);
    for (int i = 0; i < 100; i++) begin
      cyc({16'h2000 + i[15:0], 16'h0000}, 1);
      nd += int'(disp_update_o === 1'b1);
      np += int'(run_state_o === ST_PAUSE);
      tick();
    end
    idle();
    chk("refresh_count", nd inside {[1:2]}, 1);
    chk("pause_seen", np > 0, 1);
    done_test("display");
    print_verdict();
  end
endmodule
`default_nettype wire
